// *** core/ofc_map.svh ***
// Operation
// - four 16-bit user patterns, low/high byte registers
// - sample invert bit flips converter samples, not user patterns
// - clear bit per converter holds overrange cleared
// - read-only overrange-occurred bit per converter
// - user pattern repeats, or plays once
`ifndef OFC_MAP_SVH
`define OFC_MAP_SVH

// register indices; byte address is four times the index
`define OFC_IDX_W           12
`define OFC_IDX_UP1_LO      12'h551
`define OFC_IDX_UP1_HI      12'h552
`define OFC_IDX_UP2_LO      12'h553
`define OFC_IDX_UP2_HI      12'h554
`define OFC_IDX_UP3_LO      12'h555
`define OFC_IDX_UP3_HI      12'h556
`define OFC_IDX_UP4_LO      12'h557
`define OFC_IDX_UP4_HI      12'h558
`define OFC_IDX_CB_SRC_A    12'h559
`define OFC_IDX_CB_SRC_B    12'h55a
`define OFC_IDX_FMT         12'h561
`define OFC_IDX_OVR_CLR     12'h562
`define OFC_IDX_OVR_STAT    12'h563
`define OFC_IDX_TEST_CTL    12'h5f0
`define OFC_IDX_IRQ_STAT    12'h5f1
`define OFC_IDX_IRQ_MASK    12'h5f2

// reset values
`define OFC_RST_ZERO        8'h00
`define OFC_RST_CB_SRC_A    8'h00
`define OFC_RST_CB_SRC_B    8'h01
`define OFC_RST_FMT         8'h01

// field positions
`define OFC_CB0_LSB         0
`define OFC_CB1_LSB         4
`define OFC_CB2_LSB         0
`define OFC_FMT_INV_BIT     2
`define OFC_FMT_SEL_LSB     0
`define OFC_TEST_USER_BIT   0
`define OFC_TEST_SINGLE_BIT 1

// source codes and formats
`define OFC_CB_TIE_LOW      3'h0
`define OFC_CB_OVR          3'h1
`define OFC_CB_FAST         3'h3
`define OFC_CB_SYSREF       3'h5
`define OFC_FMT_OFFSET_BIN  2'h0

// bus answers
`define OFC_RESP_OKAY       2'h0
`define OFC_RESP_SLVERR     2'h2

`endif

// *** core/ofc_pkg.sv ***
`default_nettype none
package ofc_pkg;
    // user pattern player states
    typedef enum logic [1:0] {
        PAT_IDLE,
        PAT_RUN,
        PAT_DONE
    } ofc_pat_e;
    typedef logic [7:0] ofc_byte_t;
endpackage : ofc_pkg
`default_nettype wire

// *** core/ofc_reg_if.sv ***
`default_nettype none
`include "ofc_map.svh"
interface ofc_reg_if;
    logic                   wr_stb;
    logic [`OFC_IDX_W-1:0]  wr_idx;
    logic [7:0]             wr_data;
    logic                   wr_be;
    logic                   wr_hit;
    logic [`OFC_IDX_W-1:0]  rd_idx;
    logic [7:0]             rd_data;
    logic                   rd_hit;
    modport bus  (output wr_stb, wr_idx, wr_data, wr_be, rd_idx,
                  input  wr_hit, rd_data, rd_hit);
    modport regs (input  wr_stb, wr_idx, wr_data, wr_be, rd_idx,
                  output wr_hit, rd_data, rd_hit);
endinterface : ofc_reg_if
`default_nettype wire

// *** core/ofc_ctrl_mux.sv ***
`default_nettype none
`include "ofc_map.svh"
module ofc_ctrl_mux (
    // selector and candidate sources
    input  wire logic [2:0] i_sel,
    input  wire logic       i_ovr,
    input  wire logic       i_fast,
    input  wire logic       i_sysref,
    // chosen control bit
    output logic            o_bit
);
    // unlisted codes tie low
    always_comb begin
        case (i_sel)
            `OFC_CB_OVR:    o_bit = i_ovr;
            `OFC_CB_FAST:   o_bit = i_fast;
            `OFC_CB_SYSREF: o_bit = i_sysref;
            default:        o_bit = 1'b0;
        endcase
    end
endmodule : ofc_ctrl_mux
`default_nettype wire

// *** core/ofc_axil_slave.sv ***
`default_nettype none
`include "ofc_map.svh"
module ofc_axil_slave #(
    parameter int ADDR_W = 14
) (
    // clock and reset
    input  wire logic              i_clk,
    input  wire logic              i_arst_n,
    // write address and data
    input  wire logic [ADDR_W-1:0] i_awaddr,
    input  wire logic              i_awvalid,
    output logic                   o_awready,
    input  wire logic [31:0]       i_wdata,
    input  wire logic [3:0]        i_wstrb,
    input  wire logic              i_wvalid,
    output logic                   o_wready,
    // write response
    output logic [1:0]             o_bresp,
    output logic                   o_bvalid,
    input  wire logic              i_bready,
    // read channels
    input  wire logic [ADDR_W-1:0] i_araddr,
    input  wire logic              i_arvalid,
    output logic                   o_arready,
    output logic [31:0]            o_rdata,
    output logic [1:0]             o_rresp,
    output logic                   o_rvalid,
    input  wire logic              i_rready,
    // register side
    ofc_reg_if.bus                 rif
);
    initial begin
        if (ADDR_W < `OFC_IDX_W + 2) $error("ofc_axil_slave: ADDR_W too small");
    end

    logic                  aw_hold_q, aw_hold_d, w_hold_q, w_hold_d;
    logic [`OFC_IDX_W-1:0] aw_idx_q, aw_idx_d;
    logic [7:0]            w_data_q, w_data_d;
    logic                  w_be_q, w_be_d, do_wr;
    logic                  awready_q, awready_d, wready_q, wready_d, arready_q, arready_d;
    logic                  bvalid_q, bvalid_d, rvalid_q, rvalid_d;
    logic [1:0]            bresp_q, bresp_d, rresp_q, rresp_d;
    logic [31:0]           rdata_q, rdata_d;

    // address and data in either order; write fires once both held
    always_comb begin
        aw_hold_d = aw_hold_q;
        w_hold_d  = w_hold_q;
        aw_idx_d  = aw_idx_q;
        w_data_d  = w_data_q;
        w_be_d    = w_be_q;
        bvalid_d  = bvalid_q;
        bresp_d   = bresp_q;
        rvalid_d  = rvalid_q;
        rresp_d   = rresp_q;
        rdata_d   = rdata_q;
        do_wr     = aw_hold_q & w_hold_q & ~bvalid_q;
        if (i_awvalid && awready_q) begin
            aw_hold_d = 1'b1;
            aw_idx_d  = i_awaddr[`OFC_IDX_W+1:2];
        end
        if (i_wvalid && wready_q) begin
            w_hold_d = 1'b1;
            w_data_d = i_wdata[7:0];
            w_be_d   = i_wstrb[0];
        end
        if (bvalid_q && i_bready) begin
            bvalid_d = 1'b0;
        end
        if (do_wr) begin
            aw_hold_d = 1'b0;
            w_hold_d  = 1'b0;
            bvalid_d  = 1'b1;
            bresp_d   = rif.wr_hit ? `OFC_RESP_OKAY : `OFC_RESP_SLVERR;
        end
        if (rvalid_q && i_rready) begin
            rvalid_d = 1'b0;
        end
        if (i_arvalid && arready_q) begin
            rvalid_d = 1'b1;
            rdata_d  = {24'h000000, rif.rd_data};
            rresp_d  = rif.rd_hit ? `OFC_RESP_OKAY : `OFC_RESP_SLVERR;
        end
        awready_d = ~aw_hold_d & ~bvalid_d;
        wready_d  = ~w_hold_d & ~bvalid_d;
        arready_d = ~rvalid_d;
    end

    // one-cycle write strobe, live read index
    assign rif.wr_stb  = do_wr;
    assign rif.wr_idx  = aw_idx_q;
    assign rif.wr_data = w_data_q;
    assign rif.wr_be   = w_be_q;
    assign rif.rd_idx  = i_araddr[`OFC_IDX_W+1:2];

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            aw_hold_q <= 1'b0;
            w_hold_q  <= 1'b0;
            aw_idx_q  <= '0;
            w_data_q  <= 8'h00;
            w_be_q    <= 1'b0;
            awready_q <= 1'b0;
            wready_q  <= 1'b0;
            arready_q <= 1'b0;
            bvalid_q  <= 1'b0;
            bresp_q   <= 2'h0;
            rvalid_q  <= 1'b0;
            rresp_q   <= 2'h0;
            rdata_q   <= 32'h00000000;
        end else begin
            aw_hold_q <= aw_hold_d;
            w_hold_q  <= w_hold_d;
            aw_idx_q  <= aw_idx_d;
            w_data_q  <= w_data_d;
            w_be_q    <= w_be_d;
            awready_q <= awready_d;
            wready_q  <= wready_d;
            arready_q <= arready_d;
            bvalid_q  <= bvalid_d;
            bresp_q   <= bresp_d;
            rvalid_q  <= rvalid_d;
            rresp_q   <= rresp_d;
            rdata_q   <= rdata_d;
        end
    end

    assign o_awready = awready_q;
    assign o_wready  = wready_q;
    assign o_arready = arready_q;
    assign o_bvalid  = bvalid_q;
    assign o_bresp   = bresp_q;
    assign o_rvalid  = rvalid_q;
    assign o_rresp   = rresp_q;
    assign o_rdata   = rdata_q;
endmodule : ofc_axil_slave
`default_nettype wire

// *** core/ofc_top.sv ***
// Local design decision: the AXI4-Lite interface to the registers.
`default_nettype none
`include "ofc_map.svh"
module ofc_top #(
    parameter int SAMPLE_W = 14,
    parameter int NUM_VC   = 8,
    parameter int ADDR_W   = 14
) (
    // clock and reset
    input  wire logic                I_CLK_SYS,
    input  wire logic                I_ARST_N,
    // axi4-lite register port
    input  wire logic [ADDR_W-1:0]   I_AWADDR,
    input  wire logic                I_AWVALID,
    output logic                     O_AWREADY,
    input  wire logic [31:0]         I_WDATA,
    input  wire logic [3:0]          I_WSTRB,
    input  wire logic                I_WVALID,
    output logic                     O_WREADY,
    output logic [1:0]               O_BRESP,
    output logic                     O_BVALID,
    input  wire logic                I_BREADY,
    input  wire logic [ADDR_W-1:0]   I_ARADDR,
    input  wire logic                I_ARVALID,
    output logic                     O_ARREADY,
    output logic [31:0]              O_RDATA,
    output logic [1:0]               O_RRESP,
    output logic                     O_RVALID,
    input  wire logic                I_RREADY,
    // converter samples, same clock
    input  wire logic [SAMPLE_W-1:0] I_SAMPLE,
    input  wire logic                I_SAMPLE_VALID,
    input  wire logic [NUM_VC-1:0]   I_OVR,
    input  wire logic                I_FAST_THRESHOLD_FLAG,
    // sysref pin, asynchronous
    input  wire logic                I_SYSREF,
    // formatted samples
    output logic [15:0]              O_SAMPLE,
    output logic [2:0]               O_CTRL_BITS,
    output logic                     O_SAMPLE_VALID,
    // interrupt
    output logic                     O_IRQ
);
    initial begin
        if (SAMPLE_W < 2 || SAMPLE_W > 16) $error("ofc_top: SAMPLE_W out of range");
        if (NUM_VC != 8) $error("ofc_top: NUM_VC must be 8");
    end

    ofc_reg_if rif ();

    ofc_axil_slave #(.ADDR_W(ADDR_W)) u_bus (
        .i_clk     (I_CLK_SYS),
        .i_arst_n  (I_ARST_N),
        .i_awaddr  (I_AWADDR),
        .i_awvalid (I_AWVALID),
        .o_awready (O_AWREADY),
        .i_wdata   (I_WDATA),
        .i_wstrb   (I_WSTRB),
        .i_wvalid  (I_WVALID),
        .o_wready  (O_WREADY),
        .o_bresp   (O_BRESP),
        .o_bvalid  (O_BVALID),
        .i_bready  (I_BREADY),
        .i_araddr  (I_ARADDR),
        .i_arvalid (I_ARVALID),
        .o_arready (O_ARREADY),
        .o_rdata   (O_RDATA),
        .o_rresp   (O_RRESP),
        .o_rvalid  (O_RVALID),
        .i_rready  (I_RREADY),
        .rif       (rif)
    );

    // register file
    ofc_pkg::ofc_byte_t pat_lo_q [4];
    ofc_pkg::ofc_byte_t pat_hi_q [4];
    ofc_pkg::ofc_byte_t pat_lo_d [4];
    ofc_pkg::ofc_byte_t pat_hi_d [4];
    logic [7:0]         cb_src_a_q, cb_src_a_d, cb_src_b_q, cb_src_b_d;
    logic [7:0]         fmt_q, fmt_d, ovr_clr_q, ovr_clr_d, test_q, test_d;
    logic [7:0]         ovr_stat_q, ovr_stat_d, irq_stat_q, irq_stat_d, irq_mask_q, irq_mask_d;
    logic               wr;
    logic [7:0]         ovr_evt;

    // writes need byte lane 0 enabled
    assign wr      = rif.wr_stb & rif.wr_be;
    assign ovr_evt = I_OVR & ~ovr_clr_q;

    // next register values
    always_comb begin
        pat_lo_d   = pat_lo_q;
        pat_hi_d   = pat_hi_q;
        cb_src_a_d = cb_src_a_q;
        cb_src_b_d = cb_src_b_q;
        fmt_d      = fmt_q;
        ovr_clr_d  = ovr_clr_q;
        test_d     = test_q;
        irq_mask_d = irq_mask_q;
        if (wr) begin
            case (rif.wr_idx)
                `OFC_IDX_UP1_LO:   pat_lo_d[0] = rif.wr_data;
                `OFC_IDX_UP1_HI:   pat_hi_d[0] = rif.wr_data;
                `OFC_IDX_UP2_LO:   pat_lo_d[1] = rif.wr_data;
                `OFC_IDX_UP2_HI:   pat_hi_d[1] = rif.wr_data;
                `OFC_IDX_UP3_LO:   pat_lo_d[2] = rif.wr_data;
                `OFC_IDX_UP3_HI:   pat_hi_d[2] = rif.wr_data;
                `OFC_IDX_UP4_LO:   pat_lo_d[3] = rif.wr_data;
                `OFC_IDX_UP4_HI:   pat_hi_d[3] = rif.wr_data;
                `OFC_IDX_CB_SRC_A: cb_src_a_d  = rif.wr_data & 8'h77;
                `OFC_IDX_CB_SRC_B: cb_src_b_d  = rif.wr_data & 8'h07;
                `OFC_IDX_FMT:      fmt_d       = rif.wr_data & 8'h07;
                `OFC_IDX_OVR_CLR:  ovr_clr_d   = rif.wr_data;
                `OFC_IDX_TEST_CTL: test_d      = rif.wr_data & 8'h03;
                `OFC_IDX_IRQ_MASK: irq_mask_d  = rif.wr_data;
                default:           ;
            endcase
        end
        ovr_stat_d = (ovr_stat_q | I_OVR) & ~ovr_clr_q;
        // an event beats a same-cycle clear
        irq_stat_d = irq_stat_q;
        if (wr && rif.wr_idx == `OFC_IDX_IRQ_STAT) begin
            irq_stat_d = irq_stat_q & ~rif.wr_data;
        end
        irq_stat_d = irq_stat_d | ovr_evt;
    end

    // write decode: overrange status and unmapped refused
    always_comb begin
        case (rif.wr_idx)
            `OFC_IDX_UP1_LO, `OFC_IDX_UP1_HI, `OFC_IDX_UP2_LO, `OFC_IDX_UP2_HI,
            `OFC_IDX_UP3_LO, `OFC_IDX_UP3_HI, `OFC_IDX_UP4_LO, `OFC_IDX_UP4_HI,
            `OFC_IDX_CB_SRC_A, `OFC_IDX_CB_SRC_B, `OFC_IDX_FMT, `OFC_IDX_OVR_CLR,
            `OFC_IDX_TEST_CTL, `OFC_IDX_IRQ_STAT, `OFC_IDX_IRQ_MASK: rif.wr_hit = 1'b1;
            default:                                              rif.wr_hit = 1'b0;
        endcase
    end

    // read mux; unmapped reads zero, error answer
    always_comb begin
        rif.rd_hit  = 1'b1;
        rif.rd_data = 8'h00;
        case (rif.rd_idx)
            `OFC_IDX_UP1_LO:   rif.rd_data = pat_lo_q[0];
            `OFC_IDX_UP1_HI:   rif.rd_data = pat_hi_q[0];
            `OFC_IDX_UP2_LO:   rif.rd_data = pat_lo_q[1];
            `OFC_IDX_UP2_HI:   rif.rd_data = pat_hi_q[1];
            `OFC_IDX_UP3_LO:   rif.rd_data = pat_lo_q[2];
            `OFC_IDX_UP3_HI:   rif.rd_data = pat_hi_q[2];
            `OFC_IDX_UP4_LO:   rif.rd_data = pat_lo_q[3];
            `OFC_IDX_UP4_HI:   rif.rd_data = pat_hi_q[3];
            `OFC_IDX_CB_SRC_A: rif.rd_data = cb_src_a_q;
            `OFC_IDX_CB_SRC_B: rif.rd_data = cb_src_b_q;
            `OFC_IDX_FMT:      rif.rd_data = fmt_q;
            `OFC_IDX_OVR_CLR:  rif.rd_data = ovr_clr_q;
            `OFC_IDX_OVR_STAT: rif.rd_data = ovr_stat_q;
            `OFC_IDX_TEST_CTL: rif.rd_data = test_q;
            `OFC_IDX_IRQ_STAT: rif.rd_data = irq_stat_q;
            `OFC_IDX_IRQ_MASK: rif.rd_data = irq_mask_q;
            default:           rif.rd_hit  = 1'b0;
        endcase
    end

    // register state
    always_ff @(posedge I_CLK_SYS or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            for (int i = 0; i < 4; i++) begin
                pat_lo_q[i] <= `OFC_RST_ZERO;
                pat_hi_q[i] <= `OFC_RST_ZERO;
            end
            cb_src_a_q <= `OFC_RST_CB_SRC_A;
            cb_src_b_q <= `OFC_RST_CB_SRC_B;
            fmt_q      <= `OFC_RST_FMT;
            ovr_clr_q  <= `OFC_RST_ZERO;
            test_q     <= `OFC_RST_ZERO;
            ovr_stat_q <= `OFC_RST_ZERO;
            irq_stat_q <= `OFC_RST_ZERO;
            irq_mask_q <= `OFC_RST_ZERO;
        end else begin
            pat_lo_q   <= pat_lo_d;
            pat_hi_q   <= pat_hi_d;
            cb_src_a_q <= cb_src_a_d;
            cb_src_b_q <= cb_src_b_d;
            fmt_q      <= fmt_d;
            ovr_clr_q  <= ovr_clr_d;
            test_q     <= test_d;
            ovr_stat_q <= ovr_stat_d;
            irq_stat_q <= irq_stat_d;
            irq_mask_q <= irq_mask_d;
        end
    end

    // sysref is a pin; two flops before anything reads it
    logic sysref_meta_q, sysref_q;
    always_ff @(posedge I_CLK_SYS or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            sysref_meta_q <= 1'b0;
            sysref_q      <= 1'b0;
        end else begin
            sysref_meta_q <= I_SYSREF;
            sysref_q      <= sysref_meta_q;
        end
    end

    // pattern player, one step per valid sample
    ofc_pkg::ofc_pat_e pat_st_q, pat_st_d;
    logic [1:0]        pat_idx_q, pat_idx_d;
    logic              user_en;
    assign user_en = test_q[`OFC_TEST_USER_BIT];

    always_comb begin
        pat_st_d  = pat_st_q;
        pat_idx_d = pat_idx_q;
        case (pat_st_q)
            ofc_pkg::PAT_IDLE: begin
                pat_idx_d = 2'h0;
                if (user_en) pat_st_d = ofc_pkg::PAT_RUN;
            end
            ofc_pkg::PAT_RUN: begin
                if (!user_en) begin
                    pat_st_d = ofc_pkg::PAT_IDLE;
                end else if (I_SAMPLE_VALID) begin
                    pat_idx_d = pat_idx_q + 2'h1;
                    if (pat_idx_q == 2'h3 && test_q[`OFC_TEST_SINGLE_BIT]) begin
                        pat_st_d = ofc_pkg::PAT_DONE;
                    end
                end
            end
            ofc_pkg::PAT_DONE: begin
                if (!user_en) pat_st_d = ofc_pkg::PAT_IDLE;
            end
            default: pat_st_d = ofc_pkg::PAT_IDLE;
        endcase
    end

    always_ff @(posedge I_CLK_SYS or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            pat_st_q  <= ofc_pkg::PAT_IDLE;
            pat_idx_q <= 2'h0;
        end else begin
            pat_st_q  <= pat_st_d;
            pat_idx_q <= pat_idx_d;
        end
    end

    logic [2:0] cb_sel [3];
    logic [2:0] cb_bit;
    logic       ovr_any;
    assign cb_sel[0] = cb_src_a_q[`OFC_CB0_LSB +: 3];
    assign cb_sel[1] = cb_src_a_q[`OFC_CB1_LSB +: 3];
    assign cb_sel[2] = cb_src_b_q[`OFC_CB2_LSB +: 3];
    assign ovr_any   = |ovr_evt;

    for (genvar g = 0; g < 3; g++) begin : g_cb
        ofc_ctrl_mux u_mux (
            .i_sel    (cb_sel[g]),
            .i_ovr    (ovr_any),
            .i_fast   (I_FAST_THRESHOLD_FLAG),
            .i_sysref (sysref_q),
            .o_bit    (cb_bit[g])
        );
    end

    // formatting; samples arrive in twos complement
    logic [SAMPLE_W-1:0] fmt_smp;
    logic [15:0]         out_d, sample_q, sample_d;
    logic [2:0]          ctrl_q, ctrl_d;
    logic                valid_q, irq_q;

    always_comb begin
        fmt_smp = I_SAMPLE;
        if (fmt_q[`OFC_FMT_SEL_LSB +: 2] == `OFC_FMT_OFFSET_BIN) begin
            fmt_smp[SAMPLE_W-1] = ~I_SAMPLE[SAMPLE_W-1];
        end
        if (fmt_q[`OFC_FMT_INV_BIT]) fmt_smp = ~fmt_smp;
        out_d = 16'h0000;
        out_d[15 -: SAMPLE_W] = fmt_smp;
        if (pat_st_q == ofc_pkg::PAT_RUN) begin
            out_d = {pat_hi_q[pat_idx_q], pat_lo_q[pat_idx_q]};
        end else if (pat_st_q == ofc_pkg::PAT_DONE) begin
            out_d = 16'h0000;
        end
        sample_d = I_SAMPLE_VALID ? out_d : sample_q;
        ctrl_d   = I_SAMPLE_VALID ? cb_bit : ctrl_q;
    end

    // output registers; irq tracks unmasked status
    always_ff @(posedge I_CLK_SYS or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            sample_q <= 16'h0000;
            ctrl_q   <= 3'h0;
            valid_q  <= 1'b0;
            irq_q    <= 1'b0;
        end else begin
            sample_q <= sample_d;
            ctrl_q   <= ctrl_d;
            valid_q  <= I_SAMPLE_VALID;
            irq_q    <= |(irq_stat_d & irq_mask_d);
        end
    end

    assign O_SAMPLE       = sample_q;
    assign O_CTRL_BITS    = ctrl_q;
    assign O_SAMPLE_VALID = valid_q;
    assign O_IRQ          = irq_q;
endmodule : ofc_top
`default_nettype wire

// *** dv/ofc_top_monitor.sv ***
`default_nettype none
module ofc_top_monitor (
    // clock and reset
    input wire logic        I_CLK_SYS,
    input wire logic        I_ARST_N,
    // bus handshakes
    input wire logic        I_ARVALID,
    input wire logic        O_ARREADY,
    input wire logic        O_RVALID,
    input wire logic [31:0] O_RDATA,
    input wire logic        I_RREADY,
    input wire logic        O_BVALID,
    input wire logic        I_BREADY,
    // sample path
    input wire logic        I_SAMPLE_VALID,
    input wire logic        O_SAMPLE_VALID,
    input wire logic [15:0] O_SAMPLE,
    input wire logic [2:0]  O_CTRL_BITS
);
    // one domain; checks sleep in reset
    default clocking mon_cb @(posedge I_CLK_SYS);
    endclocking
    default disable iff (!I_ARST_N);

    sample_fwd_a: assert property (I_SAMPLE_VALID |=> O_SAMPLE_VALID)
        else $error("sample valid not forwarded");
    sample_gap_a: assert property (!I_SAMPLE_VALID |=> !O_SAMPLE_VALID)
        else $error("valid without sample");
    // outputs hold between samples
    sample_hold_a: assert property (!I_SAMPLE_VALID |=>
        $stable(O_SAMPLE) && $stable(O_CTRL_BITS))
        else $error("output moved without sample");
    read_answer_a: assert property (I_ARVALID && O_ARREADY |=> O_RVALID)
        else $error("read answer late");
    read_done_a: assert property (O_RVALID && I_RREADY |=> !O_RVALID)
        else $error("read answer not retired");
    read_width_a: assert property (O_RVALID |-> O_RDATA[31:8] == 24'h0)
        else $error("upper read bits not zero");
    read_block_a: assert property (O_RVALID |-> !O_ARREADY)
        else $error("second read accepted early");
    write_done_a: assert property (O_BVALID && I_BREADY |=> !O_BVALID)
        else $error("write answer not retired");
endmodule : ofc_top_monitor

bind ofc_top ofc_top_monitor i_mon (
    .I_CLK_SYS(I_CLK_SYS), .I_ARST_N(I_ARST_N), .I_ARVALID(I_ARVALID),
    .O_ARREADY(O_ARREADY), .O_RVALID(O_RVALID), .O_RDATA(O_RDATA), .I_RREADY(I_RREADY),
    .O_BVALID(O_BVALID), .I_BREADY(I_BREADY), .I_SAMPLE_VALID(I_SAMPLE_VALID),
    .O_SAMPLE_VALID(O_SAMPLE_VALID), .O_SAMPLE(O_SAMPLE), .O_CTRL_BITS(O_CTRL_BITS)
);
`default_nettype wire

// *** dv/tb.sv ***
`default_nettype none
`include "ofc_map.svh"
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {
        logic [11:0] idx;
        logic [7:0]  wd, ex;
        logic [1:0]  wr, rr;
    } ofc_row_s;
    localparam logic [1:0] OK = `OFC_RESP_OKAY;
    localparam logic [1:0] SE = `OFC_RESP_SLVERR;
    // rows: index, write, readback, write and read answers
    ofc_row_s rows [14] = '{
        '{12'h551, 8'ha5, 8'ha5, OK, OK}, '{12'h552, 8'h3c, 8'h3c, OK, OK},
        '{12'h553, 8'h11, 8'h11, OK, OK}, '{12'h554, 8'h22, 8'h22, OK, OK},
        '{12'h555, 8'h33, 8'h33, OK, OK}, '{12'h556, 8'h44, 8'h44, OK, OK},
        '{12'h557, 8'h55, 8'h55, OK, OK}, '{12'h558, 8'h66, 8'h66, OK, OK},
        '{12'h559, 8'hff, 8'h77, OK, OK}, '{12'h55a, 8'hff, 8'h07, OK, OK},
        '{12'h561, 8'hff, 8'h07, OK, OK}, '{12'h562, 8'h00, 8'h00, OK, OK},
        '{12'h563, 8'hff, 8'h00, SE, OK}, '{12'h560, 8'hff, 8'h00, SE, SE}};
    logic        clk, rst_n, awv, wv, bry, arv, rry, sv, fast, sref;
    logic        awrdy, wrdy, bv, arrdy, rv, osv, irq;
    logic [13:0] awa, ara, smp;
    logic [31:0] wd, rd;
    logic [3:0]  strb;
    logic [7:0]  ovr, f;
    logic [1:0]  br, rr;
    logic [15:0] os, e;
    logic [2:0]  ocb;
    int          bad_count, n_compared, i, m;

    ofc_top i_dut (.I_CLK_SYS(clk), .I_ARST_N(rst_n), .I_AWADDR(awa), .I_AWVALID(awv),
        .O_AWREADY(awrdy), .I_WDATA(wd), .I_WSTRB(strb), .I_WVALID(wv), .O_WREADY(wrdy),
        .O_BRESP(br), .O_BVALID(bv), .I_BREADY(bry), .I_ARADDR(ara), .I_ARVALID(arv),
        .O_ARREADY(arrdy), .O_RDATA(rd), .O_RRESP(rr), .O_RVALID(rv), .I_RREADY(rry),
        .I_SAMPLE(smp), .I_SAMPLE_VALID(sv), .I_OVR(ovr), .I_FAST_THRESHOLD_FLAG(fast),
        .I_SYSREF(sref), .O_SAMPLE(os), .O_CTRL_BITS(ocb), .O_SAMPLE_VALID(osv), .O_IRQ(irq));

    // 100 MHz system clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic print_verdict();
        $display("compared %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : print_verdict

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // a used-up wait is a hang
    task automatic stall();
        bad_count++;
        $display("ERROR %0t: handshake timeout", $time);
        print_verdict();
    endtask : stall

    task automatic wr(input logic [11:0] idx, input logic [7:0] d, input logic [1:0] er);
        logic a, w, da, dw;
        int n;
        @(posedge clk);
        {awa, wd} <= {idx, 2'b00, 24'h0, d};
        {awv, wv, bry} <= 3'b111;
        {da, dw, n} = '0;
        while (!(da && dw)) begin
            if (n++ == 40) stall();
            @(negedge clk);
            {a, w} = {awrdy, wrdy};
            @(posedge clk);
            {awv, wv} <= {awv & ~a, wv & ~w};
            {da, dw} = {da | a, dw | w};
        end
        n = 0;
        do begin
            if (n++ == 40) stall();
            @(negedge clk);
        end while (bv !== 1'b1);
        chk(32'(br), 32'(er));
        @(posedge clk);
        bry <= 1'b0;
    endtask : wr

    task automatic rd_chk(input logic [11:0] idx, input logic [7:0] ex, input logic [1:0] er);
        logic a;
        int n;
        @(posedge clk);
        {ara, arv, rry} <= {idx, 2'b00, 2'b11};
        n = 0;
        do begin
            if (n++ == 40) stall();
            @(negedge clk);
            a = arrdy;
            @(posedge clk);
        end while (!a);
        arv <= 1'b0;
        do begin
            if (n++ == 80) stall();
            @(negedge clk);
        end while (rv !== 1'b1);
        chk(rd, 32'(ex));
        chk(32'(rr), 32'(er));
        @(posedge clk);
        rry <= 1'b0;
    endtask : rd_chk

    task automatic send(input logic [13:0] s);
        @(posedge clk);
        {smp, sv} <= {s, 1'b1};
        @(posedge clk);
        sv <= 1'b0;
        @(negedge clk);
    endtask : send

    task automatic pulse(input logic [7:0] v);
        @(posedge clk);
        ovr <= v;
        @(posedge clk);
        ovr <= 8'h00;
    endtask : pulse

    // table loop, then reset and awkward cases
    initial begin
        {rst_n, awv, wv, bry, arv, rry, sv, fast, sref, awa, ara, smp, wd, ovr} = '0;
        {bad_count, n_compared} = '0;
        strb = 4'hf;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        foreach (rows[k]) begin
            wr(rows[k].idx, rows[k].wd, rows[k].wr);
            rd_chk(rows[k].idx, rows[k].ex, rows[k].rr);
        end
        $display("table done");
        // user patterns: repeat wraps, single pass ends in zero
        for (m = 1; m < 4; m += 2) begin
            wr(`OFC_IDX_TEST_CTL, 8'(m), OK);
            for (i = 0; i < 5; i++) begin
                send(14'h0);
                e = (m == 3 && i == 4) ? 16'h0 : {rows[2*(i%4)+1].ex, rows[2*(i%4)].ex};
                chk(32'(os), 32'(e));
            end
            wr(`OFC_IDX_TEST_CTL, 8'h00, OK);
        end
        $display("pattern done");
        // number format and inversion
        for (i = 0; i < 4; i++) begin
            f = {5'h0, i[1], 1'b0, i[0]};
            wr(`OFC_IDX_FMT, f, OK);
            send(14'h1234);
            e = {(i[0] ? 14'h1234 : 14'h3234) ^ {14{f[2]}}, 2'b00};
            chk(32'(os), 32'(e));
        end
        $display("format done");
        // mid-run reset restores defaults
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        chk(32'({irq, bv, rv, awrdy, wrdy, arrdy, osv, os}), 32'h0);
        rst_n <= 1'b1;
        foreach (rows[k]) begin
            e = 16'(rows[k].idx inside {12'h55a, 12'h561});
            rd_chk(rows[k].idx, e[7:0], rows[k].rr);
        end
        $display("reset done");
        // sticky status, irq mask, clear hold
        pulse(8'h82);
        rd_chk(`OFC_IDX_OVR_STAT, 8'h82, OK);
        chk(32'(irq), 32'h0);
        wr(`OFC_IDX_IRQ_MASK, 8'h02, OK);
        repeat (2) @(negedge clk);
        chk(32'(irq), 32'h1);
        wr(`OFC_IDX_IRQ_STAT, 8'h82, OK);
        repeat (2) @(negedge clk);
        chk(32'(irq), 32'h0);
        wr(`OFC_IDX_OVR_CLR, 8'h80, OK);
        pulse(8'h80);
        rd_chk(`OFC_IDX_OVR_STAT, 8'h02, OK);
        wr(`OFC_IDX_OVR_CLR, 8'h00, OK);
        $display("overrange done");
        // ignored lane-off write, then control bits
        {ovr, fast, sref, strb} <= {8'h01, 2'b11, 4'he};
        wr(`OFC_IDX_OVR_CLR, 8'hff, OK);
        strb <= 4'hf;
        wr(`OFC_IDX_CB_SRC_A, 8'h31, OK);
        wr(`OFC_IDX_CB_SRC_B, 8'h05, OK);
        send(14'h0);
        chk(32'(ocb), 32'h7);
        wr(`OFC_IDX_CB_SRC_A, 8'h00, OK);
        send(14'h0);
        chk(32'(ocb), 32'h4);
        $display("control bits done");
        print_verdict();
    end
endmodule : tb
`default_nettype wire
